// ---- include/smw_pkg.sv ----
// Shared constants and types of the system address map and write buffer.
// Assumes a 32-bit byte address space and one system clock.
package smw_pkg;

   // Register byte offsets on the configuration bus
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SRAM = 8'h04;
   localparam logic [7:0] REG_BANK_EN = 8'h08;
   localparam logic [7:0] REG_P_BASE = 8'h0c;
   localparam logic [7:0] REG_P_SIZE = 8'h10;
   localparam logic [7:0] REG_S_BASE = 8'h14;
   localparam logic [7:0] REG_S_SIZE = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1c;

   // Field positions
   localparam int CTRL_BUF_BIT = 3;
   localparam int BANK_EN_P_BIT = 0;
   localparam int BANK_EN_S_BIT = 1;
   localparam int STAT_BOOT_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_EMPTY_BIT = 2;
   localparam int STAT_FULL_BIT = 3;

   // SRAM size codes and their byte counts
   localparam int SRAM_SZ_W = 2;
   localparam logic [1:0] SRAM_32K = 2'h0;
   localparam logic [1:0] SRAM_64K = 2'h1;
   localparam logic [1:0] SRAM_96K = 2'h2;
   localparam logic [31:0] SRAM_BYTES_32K = 32'h0000_8000;
   localparam logic [31:0] SRAM_BYTES_64K = 32'h0001_0000;
   localparam logic [31:0] SRAM_BYTES_96K = 32'h0001_8000;

   // Reset values of the flash placement registers
   localparam logic [31:0] BASE_RST = 32'h0000_0000;
   localparam logic [31:0] P_SIZE_RST = 32'h0008_0000;
   localparam logic [31:0] S_SIZE_RST = 32'h0000_8000;
   localparam logic [1:0] BANK_EN_RST = 2'h0;

   // Address windows: tag bits and offset masks
   localparam logic [5:0] WIN_FLASH = 6'h00;   // addr[31:26]
   localparam logic [5:0] WIN_TCM = 6'h01;     // addr[31:26]
   localparam logic [4:0] WIN_SRAM_BUF = 5'h08; // addr[31:27]
   localparam logic [4:0] WIN_PER_BUF = 5'h09;
   localparam logic [4:0] WIN_SRAM_DIR = 5'h0a;
   localparam logic [4:0] WIN_PER_DIR = 5'h0b;
   localparam logic [3:0] WIN_EXT = 4'h3;       // addr[31:28]
   localparam int BRIDGE_SEL_BIT = 26;
   localparam logic [31:0] SRAM_OFF_MASK = 32'h0001_ffff;
   localparam logic [31:0] PER_OFF_MASK = 32'h03ff_ffff;
   localparam logic [31:0] EXT_OFF_MASK = 32'h0fff_ffff;

   typedef enum logic [2:0] {
      TGT_NONE, TGT_FLASH0, TGT_FLASH1, TGT_TCM, TGT_SRAM, TGT_EXT, TGT_BRIDGE0, TGT_BRIDGE1
   } smw_tgt_e;

   typedef struct packed {
      logic we;
      logic [3:0] sel;
      logic [31:0] addr;
      logic [31:0] wdata;
   } smw_req_s;

   typedef struct packed {
      smw_tgt_e tgt;
      logic we;
      logic [3:0] sel;
      logic [31:0] offset;
      logic [31:0] wdata;
   } smw_bus_s;

   typedef struct packed {
      logic boot_sel;
      logic en0;
      logic en1;
      logic [31:0] base0;
      logic [31:0] size0;
      logic [31:0] base1;
      logic [31:0] size1;
   } smw_flash_cfg_s;

endpackage

// ---- hw/smw_wr_fifo.sv ----
// Small write FIFO; the head entry comes out of a register.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/10ps
module smw_wr_fifo #(
   parameter int WIDTH = 72,
   parameter int ADDR_W = 2
) (
   input wire logic i_sys_clk,            // System clock
   input wire logic i_reset_n,            // Async reset, active low
   input wire logic i_push,               // Write one entry
   input wire logic [WIDTH-1:0] i_wdata,  // Entry to write
   input wire logic i_pop,                // Drop the head entry
   output logic [WIDTH-1:0] o_rdata,      // Head entry, registered
   output logic o_empty,                  // No entry held
   output logic o_full                    // No free entry
);
   localparam int DEPTH = 1 << ADDR_W;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [ADDR_W-1:0] wr_ptr;
   logic [ADDR_W-1:0] rd_ptr;
   logic [ADDR_W:0] count;
   logic [ADDR_W-1:0] next_rd_ptr;

   assign next_rd_ptr = i_pop ? rd_ptr + 1'b1 : rd_ptr;
   assign o_empty = (count == '0);
   assign o_full = (count == DEPTH[ADDR_W:0]);

   always_ff @(posedge i_sys_clk) begin
      if (i_push) begin
         mem[wr_ptr] <= i_wdata;
      end
   end

   // Bypass so that a push into an empty slot shows at the head at once
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= '0;
      end else if (i_push && wr_ptr == next_rd_ptr) begin
         o_rdata <= i_wdata;
      end else begin
         o_rdata <= mem[next_rd_ptr];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= i_push ? wr_ptr + 1'b1 : wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= count + {{ADDR_W{1'b0}}, i_push} - {{ADDR_W{1'b0}}, i_pop};
      end
   end
endmodule

// ---- hw/smw_addr_decode.sv ----
// Combinational address decoder: target, offset inside target, bufferable.
// Assumes the flash placement and SRAM size come from registers.
`timescale 1ns/10ps
module smw_addr_decode import smw_pkg::*; (
   input wire logic [31:0] i_addr,             // Byte address
   input wire logic i_is_cpu,                  // Request from the processor
   input smw_flash_cfg_s i_flash,              // Flash bank placement
   input wire logic [SRAM_SZ_W-1:0] i_sram_size, // SRAM size code
   output smw_tgt_e o_tgt,                     // Selected target
   output logic [31:0] o_offset,               // Offset inside target
   output logic o_bufferable                   // Buffered alias window
);
   logic [31:0] off0;
   logic [31:0] off1;
   logic [31:0] sram_off;
   logic [31:0] sram_bytes;
   logic hit0;
   logic hit1;
   logic sram_ok;

   assign off0 = i_addr - i_flash.base0;
   assign off1 = i_addr - i_flash.base1;
   assign hit0 = i_flash.en0 && off0 < i_flash.size0;
   assign hit1 = i_flash.en1 && off1 < i_flash.size1;
   assign sram_off = i_addr & SRAM_OFF_MASK;
   assign sram_ok = sram_off < sram_bytes;

   always_comb begin
      unique case (i_sram_size)
         SRAM_64K: sram_bytes = SRAM_BYTES_64K;
         SRAM_96K: sram_bytes = SRAM_BYTES_96K;
         default: sram_bytes = SRAM_BYTES_32K;
      endcase
   end

   // Every address falls in exactly one window or in none
   always_comb begin
      o_tgt = TGT_NONE;
      o_offset = '0;
      o_bufferable = 1'b0;
      if (i_addr[31:26] == WIN_FLASH) begin
         // Boot bank wins an overlap, so it owns address zero
         if (hit0 && (!i_flash.boot_sel || !hit1)) begin
            o_tgt = TGT_FLASH0;
            o_offset = off0;
         end else if (hit1) begin
            o_tgt = TGT_FLASH1;
            o_offset = off1;
         end
      end else if (i_addr[31:26] == WIN_TCM) begin
         if (sram_ok) begin
            o_tgt = i_is_cpu ? TGT_TCM : TGT_SRAM;
            o_offset = sram_off;
         end
      end else if (i_addr[31:27] == WIN_SRAM_BUF || i_addr[31:27] == WIN_SRAM_DIR) begin
         if (sram_ok) begin
            o_tgt = TGT_SRAM;
            o_offset = sram_off;
            o_bufferable = (i_addr[31:27] == WIN_SRAM_BUF);
         end
      end else if (i_addr[31:27] == WIN_PER_BUF || i_addr[31:27] == WIN_PER_DIR) begin
         // Bridge window base, then peripheral and register offsets
         o_tgt = i_addr[BRIDGE_SEL_BIT] ? TGT_BRIDGE1 : TGT_BRIDGE0;
         o_offset = i_addr & PER_OFF_MASK;
         o_bufferable = (i_addr[31:27] == WIN_PER_BUF);
      end else if (i_addr[31:28] == WIN_EXT) begin
         o_tgt = TGT_EXT;
         o_offset = i_addr & EXT_OFF_MASK;
      end
   end
endmodule

// ---- hw/smw_addr_map.sv ----
// System address map and write buffer between the bus masters and the slaves.
// Assumes masters hold a request until acked, and one downstream slave port
// carries a target code; configuration is reached over classic Wishbone.
// Functional notes
// - One linear 32-bit space, fixed windows
// - Reset fetch at zero hits flash bank
// - Buffering only when control bit 3 set
// - Buffered processor writes queue into FIFO
// - Full FIFO stalls the processor write
// - Direct write waits for slave completion
// - Reads always direct, never via buffer
// - Bridge base plus peripheral plus register offset
// - SRAM low window uses data TCM path
// - SRAM 0x4000_0000 window is buffered
// - SRAM 0x5000_0000 window is direct
// - SRAM size resets 32K, 64K/96K by variant
// - Only the processor may buffer writes
// - Other masters reach SRAM, always direct
// - Peripheral windows buffered and direct
// - Flash banks decode and answer independently
// - Default boot: primary at zero, secondary off
// - Boot bit selects secondary bank instead
// - Boot bit unreachable by processor writes
// - Per-bank base, size, non-boot enable
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module smw_addr_map import smw_pkg::*; #(
   parameter int FIFO_AW = 2,                   // log2 of write FIFO depth
   parameter logic [1:0] SRAM_MAX_CODE = SRAM_96K // Largest size of this variant
) (
   input wire logic i_sys_clk,                  // System clock, 20 MHz
   input wire logic i_reset_n,                  // Async reset, active low
   input wire logic i_wb_cyc,                   // Wishbone cycle
   input wire logic i_wb_stb,                   // Wishbone strobe
   input wire logic i_wb_we,                    // Wishbone write
   input wire logic [7:0] i_wb_adr,             // Wishbone byte address
   input wire logic [3:0] i_wb_sel,             // Wishbone byte enables
   input wire logic [31:0] i_wb_dat,            // Wishbone write data
   output logic [31:0] o_wb_dat,                // Wishbone read data
   output logic o_wb_ack,                       // Wishbone acknowledge
   input wire logic i_nv_boot_sel,              // Stored boot-bank bit
   input wire logic i_cpu_req,                  // Processor request
   input smw_req_s i_cpu,                       // Processor request body
   output logic o_cpu_ack,                      // Processor answer
   output logic o_cpu_err,                      // Processor unmapped
   output logic [31:0] o_cpu_rdata,             // Processor read data
   input wire logic i_mst_req,                  // Other master request
   input smw_req_s i_mst,                       // Other master body
   output logic o_mst_ack,                      // Other master answer
   output logic o_mst_err,                      // Other master unmapped
   output logic [31:0] o_mst_rdata,             // Other master read data
   output logic o_tgt_req,                      // Slave request
   output smw_bus_s o_tgt,                      // Slave request body
   input wire logic i_tgt_ack,                  // Slave done
   input wire logic [31:0] i_tgt_rdata          // Slave read data
);
   typedef enum logic [1:0] {ST_IDLE, ST_FIFO, ST_DIRECT} smw_state_e;

   smw_state_e state;
   logic owner_cpu;
   logic cpu_done;
   logic mst_done;
   logic err_done;
   logic [31:0] rdata;
   logic [31:0] ctrl;
   logic [SRAM_SZ_W-1:0] sram_size;
   logic [1:0] bank_en;
   logic [31:0] p_base;
   logic [31:0] p_size;
   logic [31:0] s_base;
   logic [31:0] s_size;
   logic boot_sel;
   logic boot_loaded;
   smw_flash_cfg_s flash_cfg;
   smw_tgt_e cpu_tgt;
   smw_tgt_e mst_tgt;
   logic [31:0] cpu_off;
   logic [31:0] mst_off;
   logic cpu_bufwin;
   logic mst_bufwin;
   logic buf_en;
   logic cpu_pending;
   logic mst_pending;
   logic cpu_buffered;
   logic fifo_push;
   logic fifo_pop;
   logic fifo_empty;
   logic fifo_full;
   smw_bus_s fifo_head;
   smw_bus_s cpu_bus;
   smw_bus_s mst_bus;
   logic wb_hit;
   logic [31:0] wb_rd;

   // Boot bank holds address zero; the other bank needs its enable bit
   assign flash_cfg.boot_sel = boot_sel;
   assign flash_cfg.en0 = !boot_sel || bank_en[BANK_EN_P_BIT];
   assign flash_cfg.en1 = boot_sel || bank_en[BANK_EN_S_BIT];
   assign flash_cfg.base0 = p_base;
   assign flash_cfg.size0 = p_size;
   assign flash_cfg.base1 = s_base;
   assign flash_cfg.size1 = s_size;

   smw_addr_decode u_cpu_dec (
      .i_addr(i_cpu.addr),
      .i_is_cpu(1'b1),
      .i_flash(flash_cfg),
      .i_sram_size(sram_size),
      .o_tgt(cpu_tgt),
      .o_offset(cpu_off),
      .o_bufferable(cpu_bufwin)
   );

   smw_addr_decode u_mst_dec (
      .i_addr(i_mst.addr),
      .i_is_cpu(1'b0),
      .i_flash(flash_cfg),
      .i_sram_size(sram_size),
      .o_tgt(mst_tgt),
      .o_offset(mst_off),
      .o_bufferable(mst_bufwin)
   );

   assign cpu_bus = '{tgt: cpu_tgt, we: i_cpu.we, sel: i_cpu.sel,
                      offset: cpu_off, wdata: i_cpu.wdata};
   assign mst_bus = '{tgt: mst_tgt, we: i_mst.we, sel: i_mst.sel,
                      offset: mst_off, wdata: i_mst.wdata};

   // A request stays high for one cycle after its answer; do not take it twice
   assign cpu_pending = i_cpu_req && !cpu_done && !err_done;
   assign mst_pending = i_mst_req && !mst_done;
   assign buf_en = ctrl[CTRL_BUF_BIT];
   // Only processor writes in a buffered window; reads never
   assign cpu_buffered = buf_en && i_cpu.we && cpu_bufwin;
   assign fifo_push = cpu_pending && cpu_buffered && !fifo_full &&
                      !(state == ST_DIRECT && owner_cpu);
   assign fifo_pop = (state == ST_IDLE) && !fifo_empty;

   smw_wr_fifo #(
      .WIDTH($bits(smw_bus_s)),
      .ADDR_W(FIFO_AW)
   ) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_push(fifo_push),
      .i_wdata(cpu_bus),
      .i_pop(fifo_pop),
      .o_rdata(fifo_head),
      .o_empty(fifo_empty),
      .o_full(fifo_full)
   );

   // Unmapped direct requests never reach the slave port
   assign o_tgt_req = (state != ST_IDLE) && (o_tgt.tgt != TGT_NONE);
   // A buffered write is answered as soon as it is queued
   assign o_cpu_ack = fifo_push || cpu_done || err_done;
   assign o_cpu_err = err_done;
   assign o_cpu_rdata = rdata;
   assign o_mst_ack = mst_done;
   assign o_mst_err = mst_done && o_tgt.tgt == TGT_NONE;
   assign o_mst_rdata = rdata;

   // Downstream sequencer: FIFO first, then direct processor, then others
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= ST_IDLE;
         owner_cpu <= 1'b0;
         o_tgt <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (!fifo_empty) begin
                  o_tgt <= fifo_head;
                  state <= ST_FIFO;
               end else if (cpu_pending && !cpu_buffered) begin
                  o_tgt <= cpu_bus;
                  owner_cpu <= 1'b1;
                  state <= ST_DIRECT;
               end else if (mst_pending) begin
                  o_tgt <= mst_bus;
                  owner_cpu <= 1'b0;
                  state <= ST_DIRECT;
               end
            end
            ST_FIFO: begin
               if (i_tgt_ack) begin
                  state <= ST_IDLE;
               end
            end
            ST_DIRECT: begin
               if (i_tgt_ack || o_tgt.tgt == TGT_NONE) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Direct answers: one-cycle pulses with the read data held in a register
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cpu_done <= 1'b0;
         mst_done <= 1'b0;
         err_done <= 1'b0;
         rdata <= '0;
      end else begin
         cpu_done <= 1'b0;
         mst_done <= 1'b0;
         err_done <= 1'b0;
         if (state == ST_DIRECT && (i_tgt_ack || o_tgt.tgt == TGT_NONE)) begin
            rdata <= (o_tgt.tgt == TGT_NONE) ? 32'h0000_0000 : i_tgt_rdata;
            if (owner_cpu) begin
               cpu_done <= (o_tgt.tgt != TGT_NONE);
               err_done <= (o_tgt.tgt == TGT_NONE);
            end else begin
               mst_done <= 1'b1;
            end
         end
      end
   end

   // Boot bank is caught once after reset; no bus path writes it
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         boot_sel <= 1'b0;
         boot_loaded <= 1'b0;
      end else if (!boot_loaded) begin
         boot_sel <= i_nv_boot_sel;
         boot_loaded <= 1'b1;
      end
   end

   assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Configuration writes; size codes above the variant's limit are ignored
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl <= '0;
         sram_size <= SRAM_32K;
         bank_en <= BANK_EN_RST;
         p_base <= BASE_RST;
         p_size <= P_SIZE_RST;
         s_base <= BASE_RST;
         s_size <= S_SIZE_RST;
      end else if (wb_hit && i_wb_we) begin
         unique case (i_wb_adr)
            REG_CTRL: ctrl <= merge(ctrl, i_wb_dat, i_wb_sel);
            REG_SRAM: begin
               if (i_wb_sel[0] && i_wb_dat[SRAM_SZ_W-1:0] <= SRAM_MAX_CODE) begin
                  sram_size <= i_wb_dat[SRAM_SZ_W-1:0];
               end
            end
            REG_BANK_EN: begin
               if (i_wb_sel[0]) begin
                  bank_en <= i_wb_dat[1:0];
               end
            end
            REG_P_BASE: p_base <= merge(p_base, i_wb_dat, i_wb_sel);
            REG_P_SIZE: p_size <= merge(p_size, i_wb_dat, i_wb_sel);
            REG_S_BASE: s_base <= merge(s_base, i_wb_dat, i_wb_sel);
            REG_S_SIZE: s_size <= merge(s_size, i_wb_dat, i_wb_sel);
            default: ;
         endcase
      end
   end

   always_comb begin
      wb_rd = '0;
      unique case (i_wb_adr)
         REG_CTRL: wb_rd = ctrl;
         REG_SRAM: wb_rd[SRAM_SZ_W-1:0] = sram_size;
         REG_BANK_EN: wb_rd[1:0] = bank_en;
         REG_P_BASE: wb_rd = p_base;
         REG_P_SIZE: wb_rd = p_size;
         REG_S_BASE: wb_rd = s_base;
         REG_S_SIZE: wb_rd = s_size;
         REG_STATUS: begin
            wb_rd[STAT_BOOT_BIT] = boot_sel;
            wb_rd[STAT_BUSY_BIT] = (state != ST_IDLE);
            wb_rd[STAT_EMPTY_BIT] = fifo_empty;
            wb_rd[STAT_FULL_BIT] = fifo_full;
         end
         default: wb_rd = '0;
      endcase
   end

   // One-cycle wait state; unmapped offsets read zero and ignore writes
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
      end else begin
         o_wb_ack <= wb_hit;
         if (wb_hit) begin
            o_wb_dat <= wb_rd;
         end
      end
   end
endmodule

// ---- tb/smw_addr_map_assertions.sv ----
// Port checker of the address map and write buffer.
// Assumes it is bound into smw_addr_map.
`timescale 1ns/10ps
module smw_addr_map_assertions import smw_pkg::*; (
   input wire logic i_sys_clk, // Clock
   input wire logic i_reset_n, // Reset
   input wire logic i_wb_cyc, // Cycle
   input wire logic i_wb_stb, // Strobe
   input logic o_wb_ack, // Reg ack
   input wire logic i_cpu_req, // Cpu req
   input smw_req_s i_cpu, // Cpu body
   input logic o_cpu_ack, // Cpu ack
   input logic o_cpu_err, // Cpu err
   input wire logic i_mst_req, // Master req
   input logic o_mst_ack, // Master ack
   input logic o_tgt_req, // Slave req
   input smw_bus_s o_tgt, // Slave body
   input wire logic i_tgt_ack // Slave done
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   wb_ack_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("register access not acked");
   tgt_hold_a: assert property (o_tgt_req && !i_tgt_ack |=> o_tgt_req && $stable(o_tgt))
      else $error("slave request changed before done");
   tgt_drop_a: assert property (o_tgt_req && i_tgt_ack |=> !o_tgt_req)
      else $error("slave request held after done");
   cpu_read_a: assert property ($rose(i_cpu_req) && !i_cpu.we |-> !o_cpu_ack)
      else $error("read answered at once");
   dir_win_a: assert property ($rose(i_cpu_req) && i_cpu.we
      && i_cpu.addr[31:27] == WIN_SRAM_DIR |-> !o_cpu_ack)
      else $error("direct window write answered at once");
   mst_direct_a: assert property ($rose(i_mst_req) |-> !o_mst_ack)
      else $error("master write buffered");
   bridge_off_a: assert property (o_tgt_req && o_tgt.tgt inside {TGT_BRIDGE0, TGT_BRIDGE1}
      |-> o_tgt.offset[31:26] == 6'h00)
      else $error("bridge offset too wide");
   err_ack_a: assert property (o_cpu_err |-> o_cpu_ack)
      else $error("error without ack");
   cover property (i_cpu_req && i_cpu.we && !o_cpu_ack [*2]);
   cover property (o_tgt_req && o_tgt.tgt == TGT_BRIDGE1);
   cover property (o_cpu_err);
endmodule

// ---- tb/smw_slave_model.sv ----
// Far-side slave: answers after a chosen wait, read data from the offset.
// Assumes one request at a time on the slave port.
`timescale 1ns/10ps
module smw_slave_model import smw_pkg::*; (
   input wire logic i_sys_clk, // Clock
   input wire logic i_reset_n, // Reset
   input wire logic i_req, // Request
   input smw_bus_s i_bus, // Body
   input wire logic [1:0] i_wait, // Wait cycles
   output logic o_ack, // Done pulse
   output logic [31:0] o_rdata // Read data
);
   logic [1:0] cnt;
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ack <= 1'b0;
         cnt <= 2'h0;
         o_rdata <= 32'h0;
      end else if (o_ack) begin
         o_ack <= 1'b0;
         o_rdata <= ~o_rdata; // Released data is not left standing
      end else if (i_req && cnt == i_wait) begin
         o_ack <= 1'b1;
         cnt <= 2'h0;
         o_rdata <= i_bus.offset ^ 32'h5a5a_0000;
      end else if (i_req) begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule

// ---- tb/test_smw_addr_map.sv ----
// Bench of the address map against a decode model.
// Assumes the slave returns offset xor 5a5a_0000 as read data.
`timescale 1ns/10ps
module test_smw_addr_map import smw_pkg::*; ();
   logic clk = 0, rst_n = 0, wcyc = 0, wstb = 0, wwe = 0, boot = 0, creq = 0, mreq = 0;
   logic [7:0] wadr = 0;
   logic [31:0] wdat = 0, wq, crd, mrd, trd, sb;
   logic wack, cack, cerr, mack, merr, treq, tack;
   logic [1:0] wt = 0;
   smw_req_s cpu = '0, mst = '0;
   smw_bus_s tbus, e;
   smw_bus_s exq[$];
   int err_count = 0, checks = 0, cyc = 0, seed = 32'hd61b, szc, n, st;
   bit bufen, pen, sen;
   logic [7:0] radr[7] = '{REG_CTRL, REG_SRAM, REG_P_BASE, REG_P_SIZE, REG_S_SIZE, REG_STATUS,
      8'h20};
   logic [31:0] rval[7] = '{'0, '0, '0, P_SIZE_RST, S_SIZE_RST, 32'h4, '0};
   logic [31:0] bases[11] = '{32'h0, 32'h0400_0000, 32'h4000_0000, 32'h4800_0000,
      32'h4c00_0000, 32'h5000_0000, 32'h5800_0000, 32'h5c00_0000, 32'h3000_0000,
      32'h8000_0000, 32'h0008_0000};
   smw_addr_map dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(wcyc), .i_wb_stb(wstb),
      .i_wb_we(wwe), .i_wb_adr(wadr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(wq),
      .o_wb_ack(wack), .i_nv_boot_sel(boot), .i_cpu_req(creq), .i_cpu(cpu), .o_cpu_ack(cack),
      .o_cpu_err(cerr), .o_cpu_rdata(crd), .i_mst_req(mreq), .i_mst(mst), .o_mst_ack(mack),
      .o_mst_err(merr), .o_mst_rdata(mrd), .o_tgt_req(treq), .o_tgt(tbus), .i_tgt_ack(tack),
      .i_tgt_rdata(trd));
   smw_slave_model slv (.i_sys_clk(clk), .i_reset_n(rst_n), .i_req(treq), .i_bus(tbus),
      .i_wait(wt), .o_ack(tack), .o_rdata(trd));
   initial begin
      forever #25 clk = ~clk;
   end
   task end_sim;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
      checks++;
      if (s !== x) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, x, s);
      end
   endtask
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wcyc <= 1'b1;
      wstb <= 1'b1;
      wwe <= we;
      wadr <= a;
      wdat <= d;
      do @(posedge clk); while (wack !== 1'b1);
      wcyc <= 1'b0;
      wstb <= 1'b0;
   endtask
   function automatic logic [34:0] dec(input logic [31:0] a, input bit c);
      logic [31:0] so;
      so = a - sb;
      if (a[31:26] == 6'h00) begin
         if (sen && so < S_SIZE_RST && (boot || !(pen && a < P_SIZE_RST)))
            return {TGT_FLASH1, so};
         return (pen && a < P_SIZE_RST) ? {TGT_FLASH0, a} : '0;
      end
      if (a[31:26] == 6'h01)
         return {c ? TGT_TCM : TGT_SRAM, a & SRAM_OFF_MASK};
      if (a[31:27] == WIN_SRAM_BUF || a[31:27] == WIN_SRAM_DIR)
         return ((a & SRAM_OFF_MASK) < 32'h8000 * (szc + 1)) ? {TGT_SRAM, a & SRAM_OFF_MASK} : '0;
      if (a[31:27] == WIN_PER_BUF || a[31:27] == WIN_PER_DIR)
         return {a[26] ? TGT_BRIDGE1 : TGT_BRIDGE0, a & PER_OFF_MASK};
      if (a[31:28] == WIN_EXT)
         return {TGT_EXT, a & EXT_OFF_MASK};
      return '0;
   endfunction
   task acc(input bit m, input logic we, input logic [31:0] a, input logic [31:0] d);
      logic [34:0] x;
      bit bf;
      x = dec(a, !m);
      bf = !m && we && bufen && (a[31:27] == WIN_SRAM_BUF || a[31:27] == WIN_PER_BUF);
      if (x[34:32] != 3'h0)
         exq.push_back('{smw_tgt_e'(x[34:32]), we, 4'hf, x[31:0], d});
      @(posedge clk);
      if (m) begin
         mst <= '{we, 4'hf, a, d};
         mreq <= 1'b1;
      end else begin
         cpu <= '{we, 4'hf, a, d};
         creq <= 1'b1;
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((m ? mack : cack) !== 1'b1);
      chk("err", {31'h0, x[34:32] == 3'h0}, {31'h0, m ? merr : cerr});
      if (!we && x[34:32] != 3'h0)
         chk("rdata", x[31:0] ^ 32'h5a5a_0000, m ? mrd : crd);
      if (!bf)
         chk("direct", 32'h1, {31'h0, n > 1});
      mreq <= 1'b0;
      creq <= 1'b0;
   endtask
   task rst_go(input logic b);
      rst_n <= 1'b0;
      boot <= b;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      bufen = 0;
      szc = 0;
      sb = '0;
      pen = !b;
      sen = b;
      repeat (2) @(posedge clk);
   endtask
   task rnd(input int cnt);
      logic [31:0] a;
      repeat (cnt) begin
         a = bases[$unsigned($random(seed)) % 11] | ($random(seed) & 32'h7ffc);
         wt <= 2'($random(seed));
         acc($random(seed), $random(seed), a, $random(seed));
      end
      while (exq.size() != 0) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim;
      end
      if (rst_n && treq && tack) begin
         if (exq.size() == 0)
            chk("extra", 32'h0, 32'h1);
         else begin
            e = exq.pop_front();
            chk("target", {28'h0, e.we, e.tgt}, {28'h0, tbus.we, tbus.tgt});
            chk("offset", e.offset, tbus.offset);
            if (e.we)
               chk("wdata", e.wdata, tbus.wdata);
         end
      end
   end
   initial begin
      rst_go(1'b0);
      foreach (radr[i]) begin
         wb(1'b0, radr[i], '0);
         chk("reg", rval[i], wq);
      end
      acc(1'b0, 1'b0, 32'h0, '0);
      acc(1'b0, 1'b1, 32'h5000_8000, 32'h1);
      rnd(30);
      wb(1'b1, REG_CTRL, 32'h8);
      bufen = 1;
      wb(1'b1, REG_SRAM, 32'h3);
      wb(1'b1, REG_SRAM, 32'h1);
      szc = 1;
      wb(1'b0, REG_SRAM, '0);
      chk("size", 32'h1, wq);
      acc(1'b1, 1'b1, 32'h4000_8000, 32'h7);
      wb(1'b1, REG_S_BASE, 32'h8_0000);
      wb(1'b1, REG_BANK_EN, 32'h3);
      sb = 32'h8_0000;
      sen = 1;
      rnd(40);
      wt <= 2'h3;
      st = 0;
      for (int i = 0; i < 8; i++) begin
         acc(1'b0, 1'b1, 32'h4000_0000 + 4 * i, i);
         if (i == 0)
            chk("accept", 32'h1, n);
         st += (n > 1);
      end
      chk("stall", 32'h1, {31'h0, st > 0});
      while (exq.size() != 0) @(posedge clk);
      rst_go(1'b1);
      wb(1'b1, REG_STATUS, '0);
      wb(1'b0, REG_STATUS, '0);
      chk("boot", 32'h5, wq);
      acc(1'b1, 1'b0, 32'h10, '0);
      acc(1'b0, 1'b0, 32'h8_0010, '0);
      end_sim;
   end
endmodule
bind smw_addr_map smw_addr_map_assertions chk_u (.i_sys_clk(i_sys_clk),
   .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
   .i_cpu_req(i_cpu_req), .i_cpu(i_cpu), .o_cpu_ack(o_cpu_ack), .o_cpu_err(o_cpu_err),
   .i_mst_req(i_mst_req), .o_mst_ack(o_mst_ack), .o_tgt_req(o_tgt_req), .o_tgt(o_tgt),
   .i_tgt_ack(i_tgt_ack));
